// ==== mcm_pkg.sv ====
package mcm_pkg;
  localparam logic [7:0] HOST_ADDR = 8'h50;
  localparam logic [7:0] DEF_MON_ADDR = 8'h6E;
  localparam logic [7:0] LEN_ONE = 8'h81;
  localparam logic [7:0] LEN_TWO = 8'h82;
  localparam logic [7:0] OP_GET_TIM = 8'h07;
  localparam logic [7:0] OP_GET_KEY = 8'h08;
  localparam logic [7:0] OP_RESET = 8'h09;
  localparam logic [7:0] OP_DISABLE = 8'h0A;
  localparam logic [7:0] OP_ENABLE = 8'h0B;
  localparam logic [7:0] OP_SAVE = 8'h0C;
  localparam logic [7:0] OP_FEAT_REPLY = 8'h02;
  localparam logic [7:0] LEN_FEAT_REPLY = 8'h88;
  localparam logic [7:0] OP_TIMING = 8'h4E;
  localparam logic [7:0] LEN_TIMING = 8'h06;
  localparam logic [7:0] OP_KEYS = 8'h4F;
  localparam logic [7:0] LEN_NO_KEYS = 8'h02;
  localparam logic [7:0] NO_KEY = 8'h00;
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] TP_SET = 8'h00;
  localparam logic [7:0] VEND_OP_LO = 8'h50;
  localparam logic [7:0] VEND_OP_HI = 8'h7F;
  localparam logic [7:0] VEND_FEAT_LO = 8'h80;
  localparam logic [7:0] VEND_FEAT_HI = 8'hFE;
  localparam int MAX_KEYS = 10;
  localparam int PAY_MAX = 11;
  localparam int ST_OOR = 7;
  localparam int ST_UNST = 6;
  localparam int ST_HPOS = 1;
  localparam int ST_VPOS = 0;
  localparam int RX_DEST = 0;
  localparam int RX_LEN = 2;
  localparam int RX_OP = 3;
  localparam int RX_SEL = 4;
  localparam int RX_KEEP = 5;
  localparam int NUM_FEAT = 4;
  localparam logic [7:0] FEAT_CODE [NUM_FEAT] = '{8'h10, 8'h12, 8'h62, 8'h20};
  localparam logic [15:0] FEAT_MAX [NUM_FEAT] = '{16'h00FF, 16'h00FF, 16'h003F, 16'h00FF};
  localparam logic [15:0] FEAT_DEF [NUM_FEAT] = '{16'h0080, 16'h0080, 16'h0020, 16'h0080};
  localparam logic [15:0] FEAT_OFF [NUM_FEAT] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [NUM_FEAT-1:0] FEAT_CAN_RST = 4'hB;
  localparam logic [NUM_FEAT-1:0] FEAT_CAN_DIS = 4'h4;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MONADDR = 8'h08;
  localparam logic [7:0] REG_FEAT0 = 8'h10;
  localparam int CTRL_REP_EN = 0;
  localparam int CTRL_AUTO_TIM = 1;
  localparam int FEAT_DIS_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_e;
endpackage

// ==== msg_tx_framer.sv ====
module msg_tx_framer import mcm_pkg::*; #(
  parameter int PAY_BYTES = PAY_MAX
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [7:0] my_addr_i,
  input wire logic [7:0] len_i,
  input wire logic [PAY_BYTES*8-1:0] pay_i,
  input wire logic [3:0] pay_cnt_i,
  output logic busy_o,
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i
);
  tx_state_e state;
  logic [7:0] addr_q;
  logic [7:0] len_q;
  logic [PAY_BYTES*8-1:0] pay_q;
  logic [4:0] total;
  logic [4:0] idx;
  logic [7:0] csum;

  function automatic logic [7:0] byte_at(input logic [4:0] i, input logic [7:0] a,
                                         input logic [7:0] l, input logic [PAY_BYTES*8-1:0] p);
    logic [7:0] r;
    if (i == 5'd0) r = HOST_ADDR;
    else if (i == 5'd1) r = a;
    else if (i == 5'd2) r = l;
    else r = p[8*(32'(i) - 3) +: 8];
    return r;
  endfunction

  assign busy_o = (state == TX_SEND);
  assign tx_valid_o = (state == TX_SEND);
  assign tx_last_o = (state == TX_SEND) && (idx == total - 5'd1);

  // Destination, source, length, payload, then XOR checksum of all sent bytes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= TX_IDLE;
      addr_q <= 8'h00;
      len_q <= 8'h00;
      pay_q <= '0;
      total <= 5'd0;
      idx <= 5'd0;
      csum <= 8'h00;
      tx_byte_o <= 8'h00;
    end else begin
      case (state)
        TX_IDLE: begin
          if (start_i) begin
            state <= TX_SEND;
            addr_q <= my_addr_i;
            len_q <= len_i;
            pay_q <= pay_i;
            total <= 5'(pay_cnt_i) + 5'd4;
            idx <= 5'd0;
            csum <= 8'h00;
            tx_byte_o <= HOST_ADDR;
          end
        end
        TX_SEND: begin
          if (tx_ready_i) begin
            if (tx_last_o) begin
              state <= TX_IDLE;
            end else begin
              idx <= idx + 5'd1;
              csum <= csum ^ tx_byte_o;
              if (idx + 5'd2 == total) tx_byte_o <= csum ^ tx_byte_o;
              else tx_byte_o <= byte_at(idx + 5'd1, addr_q, len_q, pay_q);
            end
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end
endmodule // msg_tx_framer

// ==== monitor_control_message_handler.sv ====
module monitor_control_message_handler import mcm_pkg::*; #(
  parameter int NUM_BTN = 16,
  parameter logic [7:0] MON_ADDR = DEF_MON_ADDR
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic [NUM_BTN-1:0] buttons_i,
  input wire logic [15:0] hfreq_i,
  input wire logic [15:0] vfreq_i,
  input wire logic hsync_pos_i,
  input wire logic vsync_pos_i,
  input wire logic sync_locked_i,
  input wire logic sync_out_of_range_i,
  output logic nv_save_o
);
  logic rst_q1, rst_n;
  logic [7:0] ctrl, mon_addr, save_cnt;
  logic [7:0] rx_buf [RX_KEEP];
  logic [7:0] rx_cnt, rx_xor;
  logic [NUM_BTN-1:0] btn_s1, btn_s2, btn_s3, btn_state, btn_prev;
  logic [15:0] feat_val [NUM_FEAT];
  logic [15:0] feat_hold [NUM_FEAT];
  logic [NUM_FEAT-1:0] feat_dis;
  logic key_pend, tim_pend, feat_pend, rep_zero;
  logic [1:0] rep_idx;
  logic [33:0] tim_prev;
  logic busy, launch, launch_feat, launch_tim, launch_key;
  logic frame_ok, cmd_keyq, cmd_timq, cmd_save, cmd_rst, cmd_dis, cmd_en;
  logic fhit, btn_chg, mode_chg, aw_go;
  logic [1:0] fidx, widx;
  logic [7:0] len_sel;
  logic [PAY_MAX*8-1:0] pay_sel;
  logic [3:0] cnt_sel, nbtn, nbtn_now;
  logic [7:0] tstat;

  function automatic logic [2:0] feat_find(input logic [7:0] code);
    logic [2:0] r;
    r = 3'b000;
    for (int i = 0; i < NUM_FEAT; i++) begin
      if (FEAT_CODE[i] == code) r = {1'b1, 2'(i)};
    end
    return r;
  endfunction

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Receive: keep header bytes, fold checksum, act on last byte
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt <= 8'h00;
      rx_xor <= 8'h00;
      for (int i = 0; i < RX_KEEP; i++) rx_buf[i] <= 8'h00;
    end else if (rx_valid_i) begin
      if (rx_cnt < 8'(RX_KEEP)) rx_buf[rx_cnt[2:0]] <= rx_byte_i;
      rx_cnt <= rx_last_i ? 8'h00 : rx_cnt + 8'h01;
      rx_xor <= rx_last_i ? 8'h00 : rx_xor ^ rx_byte_i;
    end
  end

  assign frame_ok = rx_valid_i && rx_last_i && ((rx_xor ^ rx_byte_i) == 8'h00)
                    && (rx_buf[RX_DEST] == mon_addr) && (rx_cnt > 8'(RX_OP));
  // Vendor primary codes never match the standard decode
  wire vend_op = in_range(rx_buf[RX_OP], VEND_OP_LO, VEND_OP_HI);
  wire is_one = frame_ok && !vend_op && (rx_buf[RX_LEN] == LEN_ONE);
  wire is_two = frame_ok && !vend_op && (rx_buf[RX_LEN] == LEN_TWO) && (rx_cnt > 8'(RX_SEL));
  assign cmd_keyq = is_one && (rx_buf[RX_OP] == OP_GET_KEY);
  assign cmd_timq = is_one && (rx_buf[RX_OP] == OP_GET_TIM);
  assign cmd_save = is_one && (rx_buf[RX_OP] == OP_SAVE);
  assign cmd_rst = is_two && (rx_buf[RX_OP] == OP_RESET);
  assign cmd_dis = is_two && (rx_buf[RX_OP] == OP_DISABLE);
  assign cmd_en = is_two && (rx_buf[RX_OP] == OP_ENABLE);
  // Vendor feature codes are masked off before the table lookup, so they never hit
  assign {fhit, fidx} = in_range(rx_buf[RX_SEL], VEND_FEAT_LO, VEND_FEAT_HI) ? 3'b000
                        : feat_find(rx_buf[RX_SEL]);
  wire do_rst = cmd_rst && fhit && FEAT_CAN_RST[fidx];
  wire do_dis = cmd_dis && fhit && FEAT_CAN_DIS[fidx] && !feat_dis[fidx];
  wire do_en = cmd_en && fhit && FEAT_CAN_DIS[fidx];

  // Button pins: three stages, a bit changes once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      btn_s1 <= '0;
      btn_s2 <= '0;
      btn_s3 <= '0;
      btn_state <= '0;
      btn_prev <= '0;
    end else begin
      btn_s1 <= buttons_i;
      btn_s2 <= btn_s1;
      btn_s3 <= btn_s2;
      btn_state <= (btn_s2 & btn_s3) | (btn_state & (btn_s2 ^ btn_s3));
      btn_prev <= btn_state;
    end
  end
  assign btn_chg = (btn_state != btn_prev);

  assign mode_chg = ({hfreq_i, vfreq_i, hsync_pos_i, vsync_pos_i} != tim_prev);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) tim_prev <= '0;
    else tim_prev <= {hfreq_i, vfreq_i, hsync_pos_i, vsync_pos_i};
  end

  // Feature values: host commands first, then software writes
  assign widx = 2'((s_axi_awaddr - REG_FEAT0) >> 2);
  wire feat_wr = aw_go && (s_axi_awaddr >= REG_FEAT0)
                 && (s_axi_awaddr < REG_FEAT0 + 8'(4 * NUM_FEAT)) && (s_axi_awaddr[1:0] == 2'b00);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_FEAT; i++) begin
        feat_val[i] <= FEAT_DEF[i];
        feat_hold[i] <= FEAT_DEF[i];
      end
      feat_dis <= '0;
    end else if (do_rst) begin
      feat_val[fidx] <= FEAT_DEF[fidx];
      feat_hold[fidx] <= FEAT_DEF[fidx];
    end else if (do_dis) begin
      feat_hold[fidx] <= feat_val[fidx];
      feat_val[fidx] <= FEAT_OFF[fidx];
      feat_dis[fidx] <= 1'b1;
    end else if (do_en) begin
      if (feat_dis[fidx]) feat_val[fidx] <= feat_hold[fidx];
      feat_dis[fidx] <= 1'b0;
    end else if (feat_wr && s_axi_wstrb[1:0] == 2'b11) begin
      if (feat_dis[widx]) feat_hold[widx] <= s_axi_wdata[15:0];
      else feat_val[widx] <= (s_axi_wdata[15:0] > FEAT_MAX[widx]) ? FEAT_MAX[widx]
                             : s_axi_wdata[15:0];
    end
  end

  // Pending replies; a new request in the launch cycle is kept
  assign launch = !busy && (feat_pend || tim_pend || key_pend);
  assign launch_feat = launch && feat_pend;
  assign launch_tim = launch && !feat_pend && tim_pend;
  assign launch_key = launch && !feat_pend && !tim_pend;
  wire rep_en = ctrl[CTRL_REP_EN];
  wire set_key = cmd_keyq || (btn_chg && rep_en);
  wire set_tim = cmd_timq || (mode_chg && rep_en && ctrl[CTRL_AUTO_TIM]);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      key_pend <= 1'b0;
      tim_pend <= 1'b0;
    end else begin
      key_pend <= (key_pend && !launch_key) || set_key;
      tim_pend <= (tim_pend && !launch_tim) || set_tim;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      feat_pend <= 1'b0;
      rep_zero <= 1'b0;
      rep_idx <= 2'd0;
    end else if (do_rst || do_dis || do_en) begin
      feat_pend <= 1'b1;
      rep_zero <= do_dis;
      rep_idx <= fidx;
    end else if (launch_feat) begin
      feat_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      nv_save_o <= 1'b0;
      save_cnt <= 8'h00;
    end else begin
      nv_save_o <= cmd_save;
      if (cmd_save) save_cnt <= save_cnt + 8'h01;
    end
  end

  // Timing status: range, lock, zero middle, polarity
  assign tstat = {sync_out_of_range_i, !sync_locked_i,
                  4'h0, hsync_pos_i, vsync_pos_i};

  // Message assembly; payload byte k sits at bits 8k
  always_comb begin
    pay_sel = '0;
    nbtn = 4'd0;
    if (launch_feat) begin
      len_sel = LEN_FEAT_REPLY;
      cnt_sel = 4'd8;
      pay_sel[63:0] = {rep_zero ? 16'h0000 : {feat_val[rep_idx][7:0], feat_val[rep_idx][15:8]},
                       rep_zero ? 16'h0000 : {FEAT_MAX[rep_idx][7:0], FEAT_MAX[rep_idx][15:8]},
                       TP_SET, FEAT_CODE[rep_idx], RC_OK, OP_FEAT_REPLY};
    end else if (launch_tim) begin
      len_sel = LEN_TIMING;
      cnt_sel = LEN_TIMING[3:0];
      pay_sel[47:0] = {vfreq_i[7:0], vfreq_i[15:8], hfreq_i[7:0], hfreq_i[15:8],
                       tstat, OP_TIMING};
    end else begin
      pay_sel[7:0] = OP_KEYS;
      for (int i = 0; i < NUM_BTN; i++) begin
        if (btn_state[i] && nbtn < 4'(MAX_KEYS)) begin
          nbtn = nbtn + 4'd1;
          pay_sel[8*nbtn +: 8] = 8'(i + 1);
        end
      end
      cnt_sel = (nbtn == 4'd0) ? 4'd2 : nbtn + 4'd1;
      len_sel = (nbtn == 4'd0) ? LEN_NO_KEYS : {4'h0, cnt_sel};
      if (nbtn == 4'd0) pay_sel[15:8] = NO_KEY;
    end
  end

  msg_tx_framer #(.PAY_BYTES(PAY_MAX)) u_framer (
    .clk_i(clk_i),
    .rst_b_i(rst_n),
    .start_i(launch),
    .my_addr_i(mon_addr),
    .len_i(len_sel),
    .pay_i(pay_sel),
    .pay_cnt_i(cnt_sel),
    .busy_o(busy),
    .tx_byte_o(tx_byte_o),
    .tx_valid_o(tx_valid_o),
    .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i)
  );

  // Register slave: write address and data taken together
  assign aw_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = aw_go;
  assign s_axi_wready = aw_go;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_known = (s_axi_awaddr == REG_CTRL) || (s_axi_awaddr == REG_STATUS)
                  || (s_axi_awaddr == REG_MONADDR) || feat_wr;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 8'h00;
      mon_addr <= MON_ADDR;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_known ? RESP_OKAY : RESP_DECERR;
        if (s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]) ctrl <= s_axi_wdata[7:0];
        if (s_axi_awaddr == REG_MONADDR && s_axi_wstrb[0]) mon_addr <= s_axi_wdata[7:0];
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire [1:0] ridx = 2'((s_axi_araddr - REG_FEAT0) >> 2);
  wire rfeat = (s_axi_araddr >= REG_FEAT0) && (s_axi_araddr < REG_FEAT0 + 8'(4 * NUM_FEAT))
               && (s_axi_araddr[1:0] == 2'b00);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == REG_CTRL) s_axi_rdata <= {24'h000000, ctrl};
      else if (s_axi_araddr == REG_STATUS)
        s_axi_rdata <= {12'h000, nbtn_now, save_cnt, 5'h00, feat_pend, tim_pend, busy};
      else if (s_axi_araddr == REG_MONADDR) s_axi_rdata <= {24'h000000, mon_addr};
      else if (rfeat) s_axi_rdata <= {15'h0000, feat_dis[ridx], feat_val[ridx]};
      else s_axi_rresp <= RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  always_comb begin
    nbtn_now = 4'd0;
    for (int i = 0; i < NUM_BTN; i++) begin
      if (btn_state[i] && nbtn_now < 4'(MAX_KEYS)) nbtn_now = nbtn_now + 4'd1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_key_request: assert property (cmd_keyq |=> key_pend)
    else $error("key request not queued");
  a_reset_value: assert property (do_rst |=>
    feat_val[$past(fidx)] == FEAT_DEF[$past(fidx)] ##0 feat_pend)
    else $error("reset did not restore factory value");
  a_reset_ignored: assert property (cmd_rst && !(fhit && FEAT_CAN_RST[fidx])
    && !feat_pend |=> !feat_pend)
    else $error("unsupported reset produced a reply");
  a_disable_zero: assert property (launch_feat && rep_zero |-> pay_sel[63:32] == 32'h0000_0000)
    else $error("disable reply fields not zero");
  a_enable_restore: assert property (do_en && feat_dis[fidx] |=>
    feat_val[$past(fidx)] == $past(feat_hold[fidx]))
    else $error("enable did not restore value");
  a_save_pulse: assert property (cmd_save |=> nv_save_o ##1 !nv_save_o || $past(cmd_save))
    else $error("save pulse wrong");
  a_report_gate: assert property (btn_chg && !rep_en && !cmd_keyq && !key_pend
    |=> !key_pend)
    else $error("key change reported while disabled");
  a_timing_frame: assert property (launch_tim |-> len_sel == LEN_TIMING && cnt_sel == 4'd6
    && pay_sel[7:0] == OP_TIMING && pay_sel[13:10] == 4'h0 && pay_sel[15] == sync_out_of_range_i)
    else $error("timing report malformed");
  a_key_length: assert property (launch_key |-> cnt_sel >= 4'd2 && cnt_sel <= 4'd11)
    else $error("key report length out of range");
  c_key_report: cover property (launch_key ##1 busy);
  c_timing_report: cover property (launch_tim);
  c_disable_reply: cover property (launch_feat && rep_zero);
  c_enable_reply: cover property (do_en ##[1:40] launch_feat);
endmodule // monitor_control_message_handler

// ==== host_link_model.sv ====
module host_link_model import mcm_pkg::*; (
  input wire logic clk_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic rx_last_o,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic slow = 1'b0;
  int end_at = 0;
  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  // Collects reply bytes; stalls every other cycle when slow
  always @(posedge clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o) begin
      got.push_back(tx_byte_i);
      if (tx_last_i === 1'b1) end_at = got.size();
    end
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  end
  // Request frame: address, source, length, code, optional selector, checksum
  task automatic send(input logic [7:0] len, op, sel);
    logic [7:0] f[$];
    logic [7:0] cs;
    f = '{DEF_MON_ADDR, HOST_ADDR, len, op};
    if (len == LEN_TWO) f.push_back(sel);
    cs = 8'h00;
    foreach (f[i]) cs ^= f[i];
    f.push_back(cs);
    foreach (f[i]) begin
      @(posedge clk_i);
      rx_byte_o <= f[i];
      rx_valid_o <= 1'b1;
      rx_last_o <= (i == f.size() - 1);
    end
    @(posedge clk_i);
    // Idle line shows a changed value, not the stale checksum
    rx_byte_o <= ~cs;
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
  endtask
endmodule // host_link_model

// ==== monitor_control_message_handler_tb.sv ====
`define CHK(nm, xp, sn) begin \
  total_checks++; \
  if ((sn) !== (xp)) begin \
    n_fail++; \
    $display("unexpected %s: expected %0h, seen %0h", nm, xp, sn); \
  end \
end
module monitor_control_message_handler_tb import mcm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] len; logic [7:0] op; logic [7:0] sel; int n; logic [95:0] e;} row_s;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rx_valid_i, rx_last_i, tx_valid_o, tx_last_o, tx_ready_i, nv_save_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0] rx_byte_i, tx_byte_o;
  logic [15:0] buttons_i = 16'h0000, hfreq_i = 16'h1234, vfreq_i = 16'h5678;
  logic hsync_pos_i = 1'b1, vsync_pos_i = 1'b0, sync_locked_i = 1'b1, sync_out_of_range_i = 1'b0;
  int n_fail = 0, total_checks = 0, n_save = 0;
  row_s rows[11];

  monitor_control_message_handler #(.NUM_BTN(16)) i_dut (.clk_i, .rst_b_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_byte_i,
    .rx_valid_i, .rx_last_i, .tx_byte_o, .tx_valid_o, .tx_last_o, .tx_ready_i, .buttons_i,
    .hfreq_i, .vfreq_i, .hsync_pos_i, .vsync_pos_i, .sync_locked_i, .sync_out_of_range_i,
    .nv_save_o);
  host_link_model i_host (.clk_i, .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i),
    .rx_last_o(rx_last_i), .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
    .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (nv_save_o === 1'b1) n_save <= n_save + 1;

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic give_up();
    n_fail++;
    conclude();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 50) give_up();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k == 50) give_up();
  endtask
  // Optional request, then the expected reply of n bytes after the addresses, or none
  task automatic exchange(input logic [7:0] len, op, sel, input int n, input logic [95:0] e);
    int k, want;
    logic [7:0] x;
    i_host.got.delete();
    i_host.end_at = 0;
    x = 8'h00;
    want = n > 0 ? n + 3 : 0;
    if (len != 8'h00) i_host.send(len, op, sel);
    for (k = 0; k < 80; k++) begin
      @(posedge clk_i);
      if (want > 0 && i_host.end_at == want) break;
    end
    if (want > 0 && k == 80) give_up();
    `CHK("frame size", want, i_host.got.size())
    if (want > 0 && i_host.got.size() == want) begin
      `CHK("last flag", want, i_host.end_at)
      `CHK("dest byte", HOST_ADDR, i_host.got[0])
      `CHK("source byte", DEF_MON_ADDR, i_host.got[1])
      for (k = 0; k < n; k++) `CHK("byte", e[8 * (n - 1 - k) +: 8], i_host.got[k + 2])
      foreach (i_host.got[j]) x ^= i_host.got[j];
      `CHK("checksum", 8'h00, x)
    end
  endtask

  initial begin
    rows = '{
      '{LEN_ONE, OP_GET_KEY, 8'h00, 3, 96'h024F00},
      '{LEN_TWO, OP_RESET, 8'h10, 9, 96'h880200100000FF0080},
      '{LEN_TWO, OP_RESET, 8'h62, 0, 96'h0},
      '{LEN_TWO, OP_DISABLE, 8'h62, 9, 96'h880200620000000000},
      '{LEN_TWO, OP_DISABLE, 8'h10, 0, 96'h0},
      '{LEN_TWO, OP_ENABLE, 8'h62, 9, 96'h8802006200003F0011},
      '{LEN_TWO, OP_ENABLE, 8'h12, 0, 96'h0},
      '{LEN_ONE, 8'h55, 8'h00, 0, 96'h0},
      '{LEN_TWO, OP_RESET, 8'h80, 0, 96'h0},
      '{LEN_ONE, OP_GET_TIM, 8'h00, 7, 96'h064E0212345678},
      '{LEN_ONE, OP_SAVE, 8'h00, 0, 96'h0}
    };
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    axi_rd(REG_MONADDR, rd, rs);
    `CHK("monitor address", DEF_MON_ADDR, rd[7:0])
    axi_rd(REG_CTRL, rd, rs);
    `CHK("control reset", 32'h0, rd)
    axi_rd(8'h40, rd, rs);
    `CHK("unmapped read", RESP_DECERR, rs)
    axi_wr(8'h44, 32'h1, rs);
    `CHK("unmapped write", RESP_DECERR, rs)
    axi_wr(REG_FEAT0, 32'h55, rs);
    axi_wr(8'h18, 32'h11, rs);
    foreach (rows[i]) exchange(rows[i].len, rows[i].op, rows[i].sel, rows[i].n, rows[i].e);
    `CHK("store pulses", 1, n_save)
    axi_rd(8'h18, rd, rs);
    `CHK("held value", 17'h00011, rd[16:0])
    i_host.slow = 1'b1;
    buttons_i <= 16'h0001;
    exchange(8'h00, 8'h00, 8'h00, 0, 96'h0);
    buttons_i <= 16'h0000;
    exchange(8'h00, 8'h00, 8'h00, 0, 96'h0);
    axi_wr(REG_CTRL, 32'h1, rs);
    buttons_i <= 16'h0005;
    exchange(8'h00, 8'h00, 8'h00, 4, 96'h034F0103);
    buttons_i <= 16'hFFFF;
    exchange(8'h00, 8'h00, 8'h00, 12, 96'h0B4F0102030405060708090A);
    buttons_i <= 16'h0000;
    exchange(8'h00, 8'h00, 8'h00, 3, 96'h024F00);
    axi_wr(REG_CTRL, 32'h3, rs);
    hfreq_i <= 16'h2000;
    sync_locked_i <= 1'b0;
    sync_out_of_range_i <= 1'b1;
    exchange(8'h00, 8'h00, 8'h00, 7, 96'h064EC220005678);
    // Host pause before asking again after an unstable count
    repeat (20) @(posedge clk_i);
    sync_locked_i <= 1'b1;
    sync_out_of_range_i <= 1'b0;
    exchange(LEN_ONE, OP_GET_TIM, 8'h00, 7, 96'h064E0220005678);
    conclude();
  end
endmodule // monitor_control_message_handler_tb
